/* core/timer_set_pkg.sv */
// register map, field layout and shared types of the general purpose timer set
// assumes a 32-bit AXI4-Lite register port and one 50 MHz master clock
package timer_set_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned IRQ_W = 7;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h54;
   localparam logic [7:0] OFF_CLEAR = 8'h58;
   localparam logic [7:0] OFF_ENABLE = 8'h5c;
   localparam logic [7:0] OFF_LAST = 8'h5c;
   localparam logic [7:0] OFF_RLOAD [2] = '{8'h00, 8'h08};
   localparam logic [7:0] OFF_RCNT [2] = '{8'h04, 8'h0c};
   localparam logic [7:0] OFF_DCFG [2] = '{8'h14, 8'h20};
   localparam logic [7:0] OFF_DLOAD [2] = '{8'h18, 8'h24};
   localparam logic [7:0] OFF_DCNT [2] = '{8'h1c, 8'h28};
   // 40-bit values: 0 slow count, 1..3 thresholds, 4 wakeup count
   localparam logic [7:0] OFF40_LO [5] = '{8'h2c, 8'h34, 8'h3c, 8'h44, 8'h4c};
   localparam logic [7:0] OFF40_HI [5] = '{8'h30, 8'h38, 8'h40, 8'h48, 8'h50};

   // control bit positions
   localparam int unsigned CTRL_RA_EN = 0;
   localparam int unsigned CTRL_D0_EN = 2;
   localparam int unsigned CTRL_SLOW_EN = 4;
   localparam int unsigned CTRL_WAKE_EN = 5;
   localparam int unsigned CTRL_W = 6;

   // interrupt status bit positions
   localparam int unsigned IRQ_RA = 0;
   localparam int unsigned IRQ_RB = 1;
   localparam int unsigned IRQ_DUAL = 2;
   localparam int unsigned IRQ_THR0 = 3;
   localparam int unsigned IRQ_WAKE = 6;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [39:0] RESET_40 = 40'h00_0000_0000;
   localparam logic [31:0] MASK_16 = 32'h0000_ffff;
   localparam logic [31:0] MASK_32 = 32'hffff_ffff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MODE_ONESHOT = 3'b001,
      MODE_PERIODIC = 3'b010,
      MODE_FREE = 3'b100
   } run_mode_e;

   typedef enum logic [1:0] {
      PRESC_1 = 2'h0,
      PRESC_16 = 2'h1,
      PRESC_256 = 2'h2
   } presc_e;

   // config word: [2:0] mode, [3] wide, [5:4] prescale
   typedef struct packed {
      presc_e presc;
      logic wide;
      run_mode_e mode;
   } dual_cfg_s;

   localparam int unsigned CFG_W = 6;
   localparam dual_cfg_s CFG_RESET = '{presc: PRESC_1, wide: 1'b1, mode: MODE_PERIODIC};

endpackage

/* core/dual_down_counter.sv */
// one counter of the paired timer unit with its prescaler
// assumes the parent gates i_run with enable, clock enable and low-power halt
`timescale 1ns/1ps
module dual_down_counter (
   input wire logic i_clk,                          // master clock
   input wire logic i_rst,                          // sync reset, also hibernation
   input wire logic i_run,                          // counting allowed this cycle
   input wire logic i_load,                         // load value written
   input wire logic [31:0] i_load_val,              // reload value
   input wire timer_set_pkg::dual_cfg_s i_cfg,      // mode, width, prescale
   output logic [31:0] o_count,                     // current count
   output logic o_evt                               // step from one to zero
);
   import timer_set_pkg::*;

   logic [7:0] presc_cnt;
   logic [31:0] next_count;
   wire [31:0] mask = i_cfg.wide ? MASK_32 : MASK_16;
   wire [31:0] cur = o_count & mask;
   wire tick_16 = presc_cnt[3:0] == 4'hf;
   wire tick_256 = presc_cnt == 8'hff;
   wire tick = i_run & ((i_cfg.presc == PRESC_1) | ((i_cfg.presc == PRESC_16) & tick_16) |
                        ((i_cfg.presc == PRESC_256) & tick_256));
   wire at_zero = cur == RESET_WORD;

   assign o_evt = tick & (cur == 32'h0000_0001);

   always_comb begin
      next_count = cur - 32'h0000_0001;
      if (at_zero) begin
         case (i_cfg.mode)
            MODE_ONESHOT: next_count = RESET_WORD;
            MODE_PERIODIC: next_count = i_load_val & mask;
            MODE_FREE: next_count = mask;
            default: next_count = mask;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         presc_cnt <= 8'h00;
         o_count <= RESET_WORD;
      end else if (i_load) begin
         presc_cnt <= 8'h00;
         o_count <= i_load_val & mask;
      end else if (i_run) begin
         presc_cnt <= presc_cnt + 8'h01;
         if (tick) begin
            o_count <= next_count;
         end
      end
   end

endmodule // dual_down_counter

/* core/general_timer_set.sv */
// general purpose timer set: two reload timers, paired timer unit, slow threshold
// timer and the 40-bit wakeup timer, behind an AXI4-Lite slave
// assumes I_LP_TICK is a one-cycle strobe per low-power clock period, synchronous to I_MCLK
`timescale 1ns/1ps
module general_timer_set (
   input wire logic I_MCLK,                      // 50 MHz master clock
   input wire logic I_SYS_RST,                   // sync reset, active high
   input wire logic I_CLK_EN,                    // freezes all state while low
   input wire logic I_LP_TICK,                   // one pulse per low-power clock period
   input wire logic I_LOW_POWER,                 // any low power mode active
   input wire logic I_HIBERNATE,                 // hibernation: timer state except the wakeup count to reset
   input wire logic I_SOC_OFF,                   // deepest off state active
   input wire logic [timer_set_pkg::ADDR_W-1:0] I_AWADDR, // write address
   input wire logic I_AWVALID,                   // write address valid
   output logic O_AWREADY,                       // write address ready
   input wire logic [31:0] I_WDATA,              // write data
   input wire logic [3:0] I_WSTRB,               // write byte strobes
   input wire logic I_WVALID,                    // write data valid
   output logic O_WREADY,                        // write data ready
   output logic [1:0] O_BRESP,                   // write response
   output logic O_BVALID,                        // write response valid
   input wire logic I_BREADY,                    // write response ready
   input wire logic [timer_set_pkg::ADDR_W-1:0] I_ARADDR, // read address
   input wire logic I_ARVALID,                   // read address valid
   output logic O_ARREADY,                       // read address ready
   output logic [31:0] O_RDATA,                  // read data
   output logic [1:0] O_RRESP,                   // read response
   output logic O_RVALID,                        // read data valid
   input wire logic I_RREADY,                    // read data ready
   output logic O_IRQ,                           // level interrupt
   output logic O_WAKE                           // wakeup timer expired, one pulse
);
   import timer_set_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      for (int b = 0; b < 4; b++) begin
         r[8*b +: 8] = st[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
      return r;
   endfunction

   // bus handshake state
   logic wr_rdy;
   logic ar_rdy;
   logic [31:0] next_rdata;

   // timer state
   logic [CTRL_W-1:0] ctrl;
   logic [31:0] rload [2];
   logic [31:0] rcnt [2];
   dual_cfg_s dcfg [2];
   logic [31:0] dload [2];
   logic [31:0] dcnt [2];
   logic [39:0] v40 [5];
   logic [IRQ_W-1:0] status;
   logic [IRQ_W-1:0] irq_en;
   logic [IRQ_W-1:0] next_status;
   logic [IRQ_W-1:0] next_irq_en;

   wire wr_en = wr_rdy & I_AWVALID & I_WVALID & I_CLK_EN;
   wire rd_en = ar_rdy & I_ARVALID & I_CLK_EN;
   wire [7:0] wa = I_AWADDR;
   wire [7:0] ra = I_ARADDR;
   wire wa_ok = (wa <= OFF_LAST) & (wa[1:0] == 2'h0);
   wire ra_ok = (ra <= OFF_LAST) & (ra[1:0] == 2'h0);
   // hibernation is treated as a reset of the general purpose timers only
   wire tm_rst = I_SYS_RST | I_HIBERNATE;
   // retention is simply a low power mode without hibernation: state holds
   wire active = I_CLK_EN & ~I_LOW_POWER;
   wire [1:0] r_run;
   wire [1:0] r_evt;
   wire [1:0] d_evt;
   wire slow_run = ctrl[CTRL_SLOW_EN] & active & I_LP_TICK;
   wire wake_run = ctrl[CTRL_WAKE_EN] & I_CLK_EN & I_SOC_OFF & I_LP_TICK & (v40[4] != RESET_40);
   wire [2:0] slow_evt;
   wire wake_evt = wake_run & (v40[4] == 40'h00_0000_0001);
   wire [4:0] step40 = {wake_run, 3'b000, slow_run};
   wire [IRQ_W-1:0] irq_set = {wake_evt, slow_evt, |d_evt, r_evt};
   wire [IRQ_W-1:0] irq_clr = (wr_en & (wa == OFF_CLEAR) & I_WSTRB[0]) ?
                              I_WDATA[IRQ_W-1:0] : {IRQ_W{1'b0}};

   // AXI4-Lite slave: ready is offered once both write channels are valid
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         wr_rdy <= 1'b0;
         O_BVALID <= 1'b0;
         O_BRESP <= RESP_OKAY;
      end else if (I_CLK_EN) begin
         wr_rdy <= I_AWVALID & I_WVALID & ~wr_rdy & ~O_BVALID;
         if (wr_en) begin
            O_BVALID <= 1'b1;
            O_BRESP <= wa_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
         end
      end
   end

   assign O_AWREADY = wr_rdy;
   assign O_WREADY = wr_rdy;
   assign O_ARREADY = ar_rdy;

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         ar_rdy <= 1'b0;
         O_RVALID <= 1'b0;
         O_RDATA <= RESET_WORD;
         O_RRESP <= RESP_OKAY;
      end else if (I_CLK_EN) begin
         ar_rdy <= I_ARVALID & ~ar_rdy & ~O_RVALID;
         if (rd_en) begin
            O_RVALID <= 1'b1;
            O_RDATA <= next_rdata;
            O_RRESP <= ra_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (I_RREADY) begin
            O_RVALID <= 1'b0;
         end
      end
   end

   // read selection; the clear register and unmapped words read as zero
   always_comb begin
      next_rdata = RESET_WORD;
      if (ra == OFF_CTRL) next_rdata = {{(32-CTRL_W){1'b0}}, ctrl};
      if (ra == OFF_STATUS) next_rdata = {{(32-IRQ_W){1'b0}}, status};
      if (ra == OFF_ENABLE) next_rdata = {{(32-IRQ_W){1'b0}}, irq_en};
      for (int i = 0; i < 2; i++) begin
         if (ra == OFF_RLOAD[i]) next_rdata = rload[i];
         if (ra == OFF_RCNT[i]) next_rdata = rcnt[i];
         if (ra == OFF_DCFG[i]) next_rdata = {{(32-CFG_W){1'b0}}, dcfg[i]};
         if (ra == OFF_DLOAD[i]) next_rdata = dload[i];
         if (ra == OFF_DCNT[i]) next_rdata = dcnt[i];
      end
      for (int k = 0; k < 5; k++) begin
         if (ra == OFF40_LO[k]) next_rdata = v40[k][31:0];
         if (ra == OFF40_HI[k]) next_rdata = {24'h00_0000, v40[k][39:32]};
      end
   end

   // control and config registers; reload and paired count registers are read-only, the 40-bit counts are writable
   always_ff @(posedge I_MCLK) begin
      if (tm_rst) begin
         ctrl <= {CTRL_W{1'b0}};
      end else if (wr_en && wa == OFF_CTRL && I_WSTRB[0]) begin
         ctrl <= I_WDATA[CTRL_W-1:0];
      end
   end

   genvar g;
   generate
      // two identical reload timers; with the paired unit and slow timer, four units
      for (g = 0; g < 2; g++) begin : g_reload
         assign r_run[g] = ctrl[CTRL_RA_EN + g] & active;
         assign r_evt[g] = r_run[g] & (rcnt[g] == 32'h0000_0001);
         always_ff @(posedge I_MCLK) begin
            if (tm_rst) begin
               rload[g] <= RESET_WORD;
               rcnt[g] <= RESET_WORD;
            end else if (wr_en && wa == OFF_RLOAD[g]) begin
               rload[g] <= merge(rload[g], I_WDATA, I_WSTRB);
               rcnt[g] <= merge(rload[g], I_WDATA, I_WSTRB);
            end else if (r_run[g]) begin
               // a disabled timer keeps its count
               rcnt[g] <= (rcnt[g] == RESET_WORD) ? rload[g] : rcnt[g] - 32'h0000_0001;
            end
         end
      end

      // paired timer unit
      for (g = 0; g < 2; g++) begin : g_dual
         wire load_wr = wr_en & (wa == OFF_DLOAD[g]);
         always_ff @(posedge I_MCLK) begin
            if (tm_rst) begin
               dcfg[g] <= CFG_RESET;
               dload[g] <= RESET_WORD;
            end else begin
               if (wr_en && wa == OFF_DCFG[g] && I_WSTRB[0]) begin
                  dcfg[g] <= dual_cfg_s'(I_WDATA[CFG_W-1:0]);
               end
               if (load_wr) dload[g] <= merge(dload[g], I_WDATA, I_WSTRB);
            end
         end
         dual_down_counter u_cnt (
            .i_clk(I_MCLK),
            .i_rst(tm_rst),
            .i_run(ctrl[CTRL_D0_EN + g] & active),
            .i_load(load_wr),
            .i_load_val(merge(dload[g], I_WDATA, I_WSTRB)),
            .i_cfg(dcfg[g]),
            .o_count(dcnt[g]),
            .o_evt(d_evt[g])
         );
      end

      // slow count, three thresholds and wakeup count
      for (g = 0; g < 5; g++) begin : g_v40
         // only the wakeup count lives outside the hibernated domain; its enable bit and O_WAKE are reset
         wire rst40 = I_SYS_RST | (I_HIBERNATE & (g != 4));
         always_ff @(posedge I_MCLK) begin
            if (rst40) begin
               v40[g] <= RESET_40;
            end else if (wr_en && wa == OFF40_LO[g]) begin
               v40[g][31:0] <= merge(v40[g][31:0], I_WDATA, I_WSTRB);
            end else if (wr_en && wa == OFF40_HI[g] && I_WSTRB[0]) begin
               v40[g][39:32] <= I_WDATA[7:0];
            end else if (step40[g]) begin
               v40[g] <= v40[g] - 40'h00_0000_0001;
            end
         end
      end

      for (g = 0; g < 3; g++) begin : g_thr
         assign slow_evt[g] = slow_run & (v40[0] == 40'(v40[g+1] + 40'h00_0000_0001));
      end
   endgenerate

   // interrupt status: a new event wins over a clear in the same cycle
   assign next_status = (status & ~irq_clr) | irq_set;
   assign next_irq_en = (wr_en && wa == OFF_ENABLE && I_WSTRB[0]) ? I_WDATA[IRQ_W-1:0] : irq_en;

   always_ff @(posedge I_MCLK) begin
      if (tm_rst) begin
         status <= {IRQ_W{1'b0}};
         irq_en <= {IRQ_W{1'b0}};
         O_IRQ <= 1'b0;
         O_WAKE <= 1'b0;
      end else if (I_CLK_EN) begin
         status <= next_status;
         irq_en <= next_irq_en;
         O_IRQ <= |(next_status & next_irq_en);
         O_WAKE <= wake_evt;
      end
   end

   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);

   property p_reload_evt;
      (r_run[0] && rcnt[0] == 32'h0000_0001 && !I_HIBERNATE) |=> status[IRQ_RA];
   endproperty
   a_reload_evt: assert property (p_reload_evt) else $error("reload a missed its event");

   property p_reload_next;
      (r_run[1] && rcnt[1] == 32'h0000_0000 && !wr_en && !I_HIBERNATE) |=>
         rcnt[1] == $past(rload[1]);
   endproperty
   a_reload_next: assert property (p_reload_next) else $error("reload b did not reload");

   property p_disabled_hold;
      (!ctrl[CTRL_RA_EN] && !wr_en && !I_HIBERNATE) |=>
         $stable(rcnt[0]) && (!status[IRQ_RA] || $past(status[IRQ_RA]));
   endproperty
   a_disabled_hold: assert property (p_disabled_hold) else $error("disabled timer moved");

   property p_low_power;
      (I_LOW_POWER && !wr_en && !I_HIBERNATE) |=>
         $stable(dcnt[0]) && $stable(dcnt[1]) && $stable(v40[0]);
   endproperty
   a_low_power: assert property (p_low_power) else $error("timer ran in low power");

   property p_slow_thr;
      (slow_run && v40[0] == 40'(v40[1] + 40'h00_0000_0001) && !I_HIBERNATE) |=>
         status[IRQ_THR0];
   endproperty
   a_slow_thr: assert property (p_slow_thr) else $error("threshold event missed");

   property p_slow_tick;
      (!I_LP_TICK && !wr_en && !I_HIBERNATE) |=> $stable(v40[0]);
   endproperty
   a_slow_tick: assert property (p_slow_tick) else $error("slow count off the tick");

   property p_wake;
      (wake_run && v40[4] == 40'h00_0000_0001 && !wr_en && !I_HIBERNATE) |=>
         O_WAKE && v40[4] == RESET_40;
   endproperty
   a_wake: assert property (p_wake) else $error("wakeup expiry not flagged");

   property p_read_count;
      (rd_en && ra == OFF_RCNT[1]) |=> O_RVALID && O_RDATA == $past(rcnt[1]);
   endproperty
   a_read_count: assert property (p_read_count) else $error("count read mismatch");

   property p_hibernate;
      I_HIBERNATE |=> rcnt[0] == RESET_WORD && dcnt[0] == RESET_WORD && v40[0] == RESET_40;
   endproperty
   a_hibernate: assert property (p_hibernate) else $error("hibernation kept state");

   property p_irq_level;
      O_IRQ == |(status & irq_en);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

   c_reload_wrap: cover property (r_run[0] && rcnt[0] == 32'h0000_0000);
   c_dual_evt: cover property (d_evt[0] ##[1:20] d_evt[1]);
   c_slow_thr: cover property (slow_evt[2]);
   c_wake: cover property (O_WAKE);

endmodule // general_timer_set

/* sim/testbench.sv */
// self-checking bench for the general purpose timer set, driven over AXI4-Lite
// assumes the design's own assertions run alongside; timers are halted between steps
`timescale 1ns/1ps
module testbench import timer_set_pkg::*;;
   logic I_MCLK = 1'b0;
   logic I_SYS_RST = 1'b1;
   logic I_CLK_EN = 1'b1;
   logic I_LP_TICK = 1'b0;
   logic I_LOW_POWER = 1'b1;
   logic I_HIBERNATE = 1'b0;
   logic I_SOC_OFF = 1'b0;
   logic [7:0] I_AWADDR = 8'h00;
   logic [7:0] I_ARADDR = 8'h00;
   logic [31:0] I_WDATA = 32'h0;
   logic [3:0] I_WSTRB = 4'hf;
   logic I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b0, I_ARVALID = 1'b0, I_RREADY = 1'b0;
   logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_IRQ, O_WAKE;
   logic [1:0] O_BRESP, O_RRESP;
   logic [31:0] O_RDATA;
   int fail_count = 0;
   int check_count = 0;
   int wake_seen = 0;
   integer seed = 32'hc9b2;

   general_timer_set u_general_timer_set (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
      .I_CLK_EN(I_CLK_EN), .I_LP_TICK(I_LP_TICK), .I_LOW_POWER(I_LOW_POWER),
      .I_HIBERNATE(I_HIBERNATE), .I_SOC_OFF(I_SOC_OFF), .I_AWADDR(I_AWADDR),
      .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB),
      .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
      .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
      .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
      .O_IRQ(O_IRQ), .O_WAKE(O_WAKE));

   always #10 I_MCLK = ~I_MCLK;

   always @(posedge I_MCLK) begin
      if (O_WAKE === 1'b1) wake_seen <= wake_seen + 1;
   end

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   // each bus task opens on a fresh edge so no signal is assigned twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int n;
      n = 0;
      @(posedge I_MCLK);
      I_AWADDR <= a;
      I_WDATA <= d;
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      I_BREADY <= 1'b1;
      do begin
         @(posedge I_MCLK);
         n++;
         if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'b0;
         if (I_WVALID && O_WREADY) I_WVALID <= 1'b0;
      end while (O_BVALID !== 1'b1 && n < 200);
      I_BREADY <= 1'b0;
      if (n >= 200) fail_count++;
      chk("bresp", {30'h0, er}, {30'h0, O_BRESP});
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int n;
      n = 0;
      @(posedge I_MCLK);
      I_ARADDR <= a;
      I_ARVALID <= 1'b1;
      I_RREADY <= 1'b1;
      do begin
         @(posedge I_MCLK);
         n++;
         if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'b0;
      end while (O_RVALID !== 1'b1 && n < 200);
      d = O_RDATA;
      I_RREADY <= 1'b0;
      if (n >= 200) fail_count++;
      chk("rresp", {30'h0, er}, {30'h0, O_RRESP});
   endtask

   task automatic chk_irq(input logic e);
      @(negedge I_MCLK);
      chk("irq", {31'h0, e}, {31'h0, O_IRQ});
      @(posedge I_MCLK);
   endtask

   // lets the master-clock timers step exactly n edges, then halts them again
   task automatic run(input int n);
      @(posedge I_MCLK);
      I_LOW_POWER <= 1'b0;
      repeat (n) @(posedge I_MCLK);
      I_LOW_POWER <= 1'b1;
   endtask

   task automatic tick(input int n);
      @(posedge I_MCLK);
      repeat (n) begin
         I_LP_TICK <= 1'b1;
         I_LOW_POWER <= 1'b0;
         @(posedge I_MCLK);
         I_LP_TICK <= 1'b0;
         I_LOW_POWER <= 1'b1;
         @(posedge I_MCLK);
      end
   endtask

   // m: 0 one-shot, 1 periodic/reload, 2 free running
   function automatic logic [31:0] model_cnt(int m, logic wide, logic [31:0] ld, int s);
      logic [31:0] c;
      logic [31:0] mask;
      mask = wide ? MASK_32 : MASK_16;
      c = ld & mask;
      for (int k = 0; k < s; k++) begin
         if (c != 32'h0) c = c - 32'h1;
         else if (m == 1) c = ld & mask;
         else if (m == 2) c = mask;
      end
      return c;
   endfunction

   initial begin
      repeat (60000) @(posedge I_MCLK);
      fail_count++;
      final_report();
   end

   initial begin
      logic [31:0] v;
      logic [31:0] ld;
      int n;
      dual_cfg_s cfg;
      run_mode_e modes [3] = '{MODE_ONESHOT, MODE_PERIODIC, MODE_FREE};
      presc_e ps [3] = '{PRESC_1, PRESC_16, PRESC_256};
      int fac [3] = '{1, 16, 256};
      repeat (6) @(posedge I_MCLK);
      I_SYS_RST <= 1'b0;
      rd(OFF_CTRL, v);
      chk("ctrl_reset", RESET_WORD, v);
      rd(OFF_DCFG[1], v);
      chk("cfg_reset", {26'h0, CFG_RESET}, v);
      rd(8'h60, v, RESP_SLVERR);
      chk("unmapped", 32'h0, v);
      rd(8'h02, v, RESP_SLVERR);
      wr(8'h60, 32'h1, RESP_SLVERR);
      for (int i = 0; i < 2; i++) begin
         n = 4 + ($unsigned($random(seed)) % 16);
         wr(OFF_RLOAD[i], n);
         wr(OFF_CTRL, 32'h1 << (CTRL_RA_EN + i));
         wr(OFF_ENABLE, 32'h1 << (IRQ_RA + i));
         rd(OFF_RCNT[i], v);
         chk("rl_count", n, v);
         run(n - 1);
         chk_irq(1'b0);
         run(3);
         rd(OFF_RCNT[i], v);
         chk("rl_reload", model_cnt(1, 1'b1, n, n + 2), v);
         rd(OFF_STATUS, v);
         chk("rl_status", 32'h1 << (IRQ_RA + i), v);
         chk_irq(1'b1);
         I_CLK_EN <= 1'b0;
         run(5);
         I_CLK_EN <= 1'b1;
         wr(OFF_CTRL, 32'h0);
         run(5);
         rd(OFF_RCNT[i], v);
         chk("rl_hold", model_cnt(1, 1'b1, n, n + 2), v);
         wr(OFF_ENABLE, 32'h0);
         chk_irq(1'b0);
         wr(OFF_CLEAR, MASK_32);
         rd(OFF_STATUS, v);
         chk("status_clear", 32'h0, v);
      end
      wr(OFF_ENABLE, 32'h1 << IRQ_DUAL);
      for (int j = 0; j < 2; j++) begin
         ld = (j == 0) ? 32'h0001_0003 : 32'h3;
         for (int m = 0; m < 3; m++) begin
            cfg = '{presc: PRESC_1, wide: j[0], mode: modes[m]};
            wr(OFF_DCFG[j], {26'h0, cfg});
            wr(OFF_CTRL, 32'h1 << (CTRL_D0_EN + j));
            wr(OFF_DLOAD[j], ld);
            rd(OFF_DCNT[j], v);
            chk("dual_width", model_cnt(m, j[0], ld, 0), v);
            run(5);
            rd(OFF_DCNT[j], v);
            chk("dual_mode", model_cnt(m, j[0], ld, 5), v);
            chk_irq(1'b1);
            wr(OFF_CLEAR, MASK_32);
         end
         for (int p = 0; p < 3; p++) begin
            cfg = '{presc: ps[p], wide: 1'b1, mode: MODE_PERIODIC};
            wr(OFF_DCFG[j], {26'h0, cfg});
            wr(OFF_DLOAD[j], 32'd1000);
            run(3 * fac[p]);
            rd(OFF_DCNT[j], v);
            chk("prescale", model_cnt(1, 1'b1, 32'd1000, 3), v);
         end
      end
      wr(OFF_CTRL, 32'h1 << CTRL_SLOW_EN);
      wr(OFF_ENABLE, 32'h38);
      wr(OFF40_HI[0], 32'h0);
      wr(OFF40_LO[0], 32'h6);
      for (int t = 1; t < 4; t++) begin
         wr(OFF40_HI[t], 32'h0);
         wr(OFF40_LO[t], 32'h5 - t);
      end
      wr(OFF_CLEAR, MASK_32);
      tick(1);
      run(30);
      rd(OFF40_LO[0], v);
      chk("slow_step", 32'h5, v);
      I_LP_TICK <= 1'b1;
      @(posedge I_MCLK);
      I_LP_TICK <= 1'b0;
      rd(OFF40_LO[0], v);
      chk("slow_halt", 32'h5, v);
      rd(OFF40_LO[0], ld);
      chk("slow_twice", 32'h5, ld);
      tick(3);
      rd(OFF_STATUS, v);
      chk("slow_thr", 32'h38, v);
      chk_irq(1'b1);
      wr(OFF_CTRL, 32'h1 << CTRL_WAKE_EN);
      wr(OFF40_HI[4], 32'h0);
      wr(OFF40_LO[4], 32'h2);
      I_SOC_OFF <= 1'b1;
      tick(1);
      chk("wake_early", 32'h0, wake_seen);
      tick(3);
      chk("wake_pulse", 32'h1, wake_seen);
      rd(OFF_STATUS, v);
      chk("wake_status", 32'h1 << IRQ_WAKE, v & (32'h1 << IRQ_WAKE));
      I_SOC_OFF <= 1'b0;
      wr(OFF_RLOAD[0], 32'h55);
      I_HIBERNATE <= 1'b1;
      @(posedge I_MCLK);
      I_HIBERNATE <= 1'b0;
      rd(OFF_RLOAD[0], v);
      chk("hib_load", RESET_WORD, v);
      rd(OFF_STATUS, v);
      chk("hib_status", RESET_WORD, v);
      chk_irq(1'b0);
      final_report();
   end
endmodule // testbench
